// *** rtl/cpmc_defines.vh ***
// Purpose: Constants for the clock and power-mode controller.
// Assumes: APB byte addresses are four times the register index.
// Notes:   Definitions only.
`ifndef CPMC_DEFINES_VH
`define CPMC_DEFINES_VH
`define CPMC_IDX_CLK_SRC      8'ha3
`define CPMC_IDX_PWR_DOWN     8'ha4
`define CPMC_IDX_LF_CTRL      8'had
`define CPMC_CLK_SRC_RST      8'h00
`define CPMC_PWR_DOWN_RST     8'h00
`define CPMC_LF_SRC_RST       3'h7
`define CPMC_BIT_KEEP_XTAL    7
`define CPMC_BIT_BYPASS       6
`define CPMC_BIT_XTAL_IRQ_EN  3
`define CPMC_OSC_BOTH         2'h0
`define CPMC_OSC_RC_ONLY      2'h1
`define CPMC_OSC_XTAL_ONLY    2'h2
`define CPMC_PD_NONE          3'h0
`define CPMC_PD_DEEP_SLEEP    3'h1
`define CPMC_PD_MEM_RET_OFF   3'h2
`define CPMC_PD_MEM_RET_ON    3'h3
`define CPMC_PD_REG_RET       3'h4
`define CPMC_PD_STANDBY       3'h7
`define CPMC_LF_SLOW_XTAL     3'h0
`define CPMC_LF_SLOW_RC       3'h1
`define CPMC_LF_SYNTH         3'h2
`define CPMC_LF_XTAL_PIN      3'h3
`define CPMC_LF_DIG_PIN       3'h4
`define CPMC_LF_NONE          3'h7
`endif

// *** rtl/cpmc_top.v ***
// Purpose: Clock source, clock divider and power-down mode control with an APB slave.
// Assumes: All inputs synchronous to clk_in; oscillators and wakeup logic are outside.
// Notes:   The 16 MHz MCU clock is represented by enable pulses of a divided clk_in.
//
// How it works
// - Keep-crystal bit holds the fast crystal on during register retention.
// - Bypass bit takes MCU clock from the crystal input pin.
// - Start field: 00 both, 01 RC only, 10 crystal only, 11 reserved.
// - With both started, run from RC then switch to crystal when ready.
// - New start field applies only after retention or deep sleep.
// - Bit 3 enables crystal-ready wakeup and interrupt.
// - Bits 2:0 halve MCU clock from 16 MHz down to 125 kHz.
// - Low-frequency control bit 7 reads the low-frequency clock level.
// - Low-frequency control bit 6 reads ready.
// - Low-frequency control bit 3 reads one when crystal drives the MCU.
// - Low-frequency source field selects one of five sources or none.
// - Fast crystal stops in deep sleep and memory retention.
// - MCU waits for an operating low-frequency clock when one is selected.
// - Power-down bits 7, 6, 5 are pin, tick and comparator wake flags.
// - Wake flags clear on read or on entering power-down.
// - Write of a nonzero code other than 101 or 110 to bits 2:0 enters the coded power-down mode.
// - Reading bits 2:0 returns previous power-down mode.
// - Both register retention variants use code 100.
// - Register retention wakeup resumes without system reset.
`timescale 1ns/1ps
`include "cpmc_defines.vh"

module cpmc_top
(
    // Clock and reset.
    input  wire        clk_in,
    input  wire        sys_rst_in,
    // APB slave.
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [11:0] paddr_in,
    input  wire [31:0] pwdata_in,
    output wire [31:0] prdata_out,
    output wire        pready_out,
    output wire        pslverr_out,
    // Oscillator status and pins.
    input  wire        fast_crystal_ready_in,
    input  wire        fast_rc_ready_in,
    input  wire        crystal_input_pin_in,
    input  wire        low_freq_clock_in,
    input  wire        low_freq_ready_in,
    // Wakeup events.
    input  wire        wake_pin_in,
    input  wire        wake_tick_in,
    input  wire        wake_comp_in,
    input  wire        wake_irq_in,
    // Oscillator and power controls.
    output reg         fast_crystal_osc_en_out,
    output reg         fast_rc_osc_en_out,
    output reg  [2:0]  low_freq_src_out,
    output reg         mcu_clk_en_out,
    output reg         mcu_src_crystal_out,
    output reg         mcu_src_bypass_out,
    output reg         mcu_run_out,
    output reg  [2:0]  power_mode_out,
    output reg         system_reset_req_out,
    output reg         fast_crystal_ready_irq_out
);

    localparam [1:0] ST_ACTIVE = 2'h0;
    localparam [1:0] ST_DOWN   = 2'h1;
    localparam [1:0] ST_WAKE   = 2'h2;

    // ********************************************************
    // APB decode
    // ********************************************************
    wire       acc_en   = psel_in & penable_in;
    wire       idx_ok   = (paddr_in[1:0] == 2'h0);
    wire [9:0] idx      = paddr_in[11:2];
    wire       hit_clk  = idx_ok & (idx == {2'h0, `CPMC_IDX_CLK_SRC});
    wire       hit_pd   = idx_ok & (idx == {2'h0, `CPMC_IDX_PWR_DOWN});
    wire       hit_lf   = idx_ok & (idx == {2'h0, `CPMC_IDX_LF_CTRL});
    wire       hit_any  = hit_clk | hit_pd | hit_lf;
    wire       wr_stb   = acc_en & pwrite_in;
    wire       rd_pd    = acc_en & ~pwrite_in & hit_pd;

    assign pready_out  = 1'b1;
    assign pslverr_out = acc_en & ~hit_any;

    reg  [7:0] clk_src_q;
    reg  [1:0] osc_start_q;
    reg  [2:0] lf_src_q;
    reg  [2:0] prev_mode_q;
    reg  [2:0] wake_flags_q;
    reg  [1:0] state_q;
    reg  [2:0] div_cnt_q;
    reg  [6:0] tick_cnt_q;
    reg        xtal_rdy_q;
    reg  [7:0] rd_mux;
    reg  [31:0] prdata_q;

    // ********************************************************
    // Register writes
    // ********************************************************
    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            clk_src_q <= `CPMC_CLK_SRC_RST;
            lf_src_q  <= `CPMC_LF_SRC_RST;
        end
        else if (wr_stb)
        begin
            if (hit_clk)
                clk_src_q <= pwdata_in[7:0];
            if (hit_lf)
                lf_src_q <= pwdata_in[2:0];
        end
    end

    // ********************************************************
    // Power-down sequencer
    // ********************************************************
    wire pd_write  = wr_stb & hit_pd & (pwdata_in[2:0] != `CPMC_PD_NONE);
    wire pd_legal  = (pwdata_in[2:0] != 3'h5) && (pwdata_in[2:0] != 3'h6);
    wire any_wake  = wake_pin_in | wake_tick_in | wake_comp_in
                   | (wake_irq_in & (power_mode_out == `CPMC_PD_STANDBY))
                   | (fast_crystal_ready_in & ~xtal_rdy_q
                      & clk_src_q[`CPMC_BIT_XTAL_IRQ_EN]);
    wire lf_active = (lf_src_q != `CPMC_LF_NONE) && (lf_src_q != 3'h5)
                   && (lf_src_q != 3'h6);

    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            state_q              <= ST_ACTIVE;
            power_mode_out       <= `CPMC_PD_NONE;
            prev_mode_q          <= `CPMC_PD_NONE;
            osc_start_q          <= `CPMC_OSC_BOTH;
            wake_flags_q         <= 3'h0;
            system_reset_req_out <= 1'b0;
        end
        else
        begin
            system_reset_req_out <= 1'b0;
            case (state_q)
                ST_ACTIVE:
                begin
                    if (pd_write && pd_legal)
                    begin
                        power_mode_out <= pwdata_in[2:0];
                        prev_mode_q    <= pwdata_in[2:0];
                        wake_flags_q   <= 3'h0;
                        state_q        <= ST_DOWN;
                    end
                    else if (rd_pd)
                        wake_flags_q <= 3'h0;
                end
                ST_DOWN:
                begin
                    if (any_wake)
                    begin
                        wake_flags_q <= {wake_pin_in, wake_tick_in,
                                         wake_comp_in & (power_mode_out
                                         != `CPMC_PD_STANDBY)};
                        // Start field latched on wakeup from any mode but standby.
                        if (power_mode_out != `CPMC_PD_STANDBY)
                            osc_start_q <= clk_src_q[5:4];
                        // Only deep sleep and memory retention reset.
                        if ((power_mode_out == `CPMC_PD_DEEP_SLEEP) ||
                            (power_mode_out == `CPMC_PD_MEM_RET_OFF) ||
                            (power_mode_out == `CPMC_PD_MEM_RET_ON))
                            system_reset_req_out <= 1'b1;
                        state_q <= ST_WAKE;
                    end
                end
                ST_WAKE:
                begin
                    if (!lf_active || low_freq_ready_in)
                    begin
                        power_mode_out <= `CPMC_PD_NONE;
                        state_q        <= ST_ACTIVE;
                    end
                end
                default:
                    state_q <= ST_ACTIVE;
            endcase
        end
    end

    // ********************************************************
    // Oscillator control and MCU clock selection
    // ********************************************************
    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            fast_crystal_osc_en_out    <= 1'b1;
            fast_rc_osc_en_out         <= 1'b1;
            low_freq_src_out           <= `CPMC_LF_SRC_RST;
            mcu_src_crystal_out        <= 1'b0;
            mcu_src_bypass_out         <= 1'b0;
            mcu_run_out                <= 1'b0;
            xtal_rdy_q                 <= 1'b0;
            fast_crystal_ready_irq_out <= 1'b0;
        end
        else
        begin
            xtal_rdy_q <= fast_crystal_ready_in;
            fast_rc_osc_en_out <= (osc_start_q != `CPMC_OSC_XTAL_ONLY)
                                && (osc_start_q != 2'h3);
            // Crystal stopped in deep sleep and memory retention.
            if ((power_mode_out == `CPMC_PD_DEEP_SLEEP) ||
                (power_mode_out == `CPMC_PD_MEM_RET_OFF) ||
                (power_mode_out == `CPMC_PD_MEM_RET_ON))
                fast_crystal_osc_en_out <= 1'b0;
            // Keep crystal on in register retention only if asked.
            else if (power_mode_out == `CPMC_PD_REG_RET)
                fast_crystal_osc_en_out <= clk_src_q[`CPMC_BIT_KEEP_XTAL];
            else
                fast_crystal_osc_en_out <= (osc_start_q == `CPMC_OSC_BOTH)
                                        || (osc_start_q == `CPMC_OSC_XTAL_ONLY);
            // Register retention timers follow low-frequency source.
            low_freq_src_out <= lf_src_q;
            mcu_src_bypass_out <= clk_src_q[`CPMC_BIT_BYPASS];
            mcu_src_crystal_out <= fast_crystal_ready_in & fast_crystal_osc_en_out
                                 & (osc_start_q != `CPMC_OSC_RC_ONLY);
            mcu_run_out <= (state_q == ST_ACTIVE);
            // Crystal-ready interrupt gated by bit 3.
            fast_crystal_ready_irq_out <= fast_crystal_ready_in & ~xtal_rdy_q
                                        & clk_src_q[`CPMC_BIT_XTAL_IRQ_EN];
        end
    end

    // ********************************************************
    // MCU clock divider
    // ********************************************************
    // clk_in is 50 MHz; a 16 MHz enable is approximated by one pulse in three.
    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            div_cnt_q      <= 3'h0;
            tick_cnt_q     <= 7'h00;
            mcu_clk_en_out <= 1'b0;
        end
        else
        begin
            mcu_clk_en_out <= 1'b0;
            if (div_cnt_q == 3'h2)
            begin
                div_cnt_q <= 3'h0;
                if ((tick_cnt_q & ((7'h01 << clk_src_q[2:0]) - 7'h01)) == 7'h00)
                    mcu_clk_en_out <= (state_q == ST_ACTIVE);
                tick_cnt_q <= tick_cnt_q + 7'h01;
            end
            else
                div_cnt_q <= div_cnt_q + 3'h1;
        end
    end

    // ********************************************************
    // Read data
    // ********************************************************
    always @*
    begin
        rd_mux = 8'h00;
        if (hit_clk)
            rd_mux = clk_src_q;
        else if (hit_pd)
            rd_mux = {wake_flags_q, 2'h0, prev_mode_q};
        else if (hit_lf)
            rd_mux = {low_freq_clock_in, low_freq_ready_in, 2'h0,
                      mcu_src_crystal_out, lf_src_q};
    end

    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            prdata_q <= 32'h0000_0000;
        else if (psel_in & ~penable_in & ~pwrite_in)
            prdata_q <= {24'h00_0000, rd_mux};
    end

    assign prdata_out = prdata_q;

endmodule

// *** verification/cpmc_osc_model.sv ***
// Purpose: Oscillator model beside the clock and power-mode controller.
// Assumes: One reference clock; oscillator start times are shortened.
// Notes:   The slow clock stands low whenever it is switched off.
`timescale 1ns/1ps
module cpmc_osc_model
(
    // Clock and controls.
    input  wire clk_in,
    input  wire xtal_en_in,
    input  wire lf_on_in,
    // Oscillator status.
    output reg  xtal_rdy_out = 1'b0,
    output reg  lf_clk_out = 1'b0,
    output wire lf_rdy_out
);
    // ****************
    // Start-up timing
    // ****************
    reg [3:0] cnt_q = 4'h0;

    assign lf_rdy_out = lf_on_in;
    // A crystal that was stopped needs its whole start time again.
    always @(posedge clk_in)
    begin
        cnt_q        <= xtal_en_in ? cnt_q + {3'h0, cnt_q != 4'hf} : 4'h0;
        xtal_rdy_out <= xtal_en_in && cnt_q > 4'hc;
        lf_clk_out   <= lf_on_in & ~lf_clk_out;
    end
endmodule

// *** verification/cpmc_properties.sv ***
// Purpose: Port properties of the clock and power-mode controller.
// Assumes: Byte address is four times the register index.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/1ps
module cpmc_properties
(
    // Clock, reset and bus.
    input wire        clk_in,
    input wire        sys_rst_in,
    input wire        psel_in,
    input wire        penable_in,
    input wire        pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    // Status and controller outputs.
    input wire        fast_crystal_ready_in,
    input wire [2:0]  low_freq_src_out,
    input wire        mcu_clk_en_out,
    input wire        mcu_src_bypass_out,
    input wire        mcu_run_out,
    input wire [2:0]  power_mode_out,
    input wire        fast_crystal_ready_irq_out
);
    // ****************
    // Write decoding
    // ****************
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    wire      wr    = psel_in && penable_in && pwrite_in;
    wire      wr_cs = wr && paddr_in == 12'h28c;
    wire      wr_pd = wr && paddr_in == 12'h290;
    wire      wr_lf = wr && paddr_in == 12'h2b4;
    wire      rsv   = pwdata_in[2:0] == 3'h5 || pwdata_in[2:0] == 3'h6;
    wire      idle  = wr_pd && mcu_run_out && power_mode_out == 3'h0;
    reg [2:0] code_q;

    always @(posedge clk_in)
        if (wr_pd)
            code_q <= pwdata_in[2:0];
    sequence s_pd_go;
        idle && !rsv && pwdata_in[2:0] != 3'h0;
    endsequence
    sequence s_pd_rsv;
        idle && rsv;
    endsequence
    bypass_follow_a: assert property ($changed(mcu_src_bypass_out) |-> $past(wr_cs) || $past(wr_cs, 2))
        else $error("bypass flag changed without a write");
    lf_follow_a: assert property ($changed(low_freq_src_out) |-> $past(wr_lf) || $past(wr_lf, 2))
        else $error("slow clock source changed without a write");
    pd_enter_a: assert property (s_pd_go |-> ##[1:2] (power_mode_out == code_q))
        else $error("power-down code not entered");
    pd_reserved_a: assert property (s_pd_rsv |=> (power_mode_out == 3'h0) [*2])
        else $error("reserved power-down code entered");
    pd_cause_a: assert property ($rose(power_mode_out != 3'h0) |-> $past(wr_pd) || $past(wr_pd, 2))
        else $error("power-down entered without a write");
    irq_cause_a: assert property (fast_crystal_ready_irq_out |-> $past(fast_crystal_ready_in) &&
        !($past(fast_crystal_ready_in, 2) && $past(fast_crystal_ready_in, 3)))
        else $error("crystal interrupt without a rising ready");
    irq_pulse_a: assert property (fast_crystal_ready_irq_out |=> !fast_crystal_ready_irq_out)
        else $error("crystal interrupt longer than one cycle");
    tick_gap_a: assert property (mcu_clk_en_out |=> (!mcu_clk_en_out) [*2])
        else $error("clock enable pulses closer than three cycles");
endmodule

bind cpmc_top cpmc_properties u_cpmc_props
(
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .fast_crystal_ready_in(fast_crystal_ready_in), .low_freq_src_out(low_freq_src_out),
    .mcu_clk_en_out(mcu_clk_en_out), .mcu_src_bypass_out(mcu_src_bypass_out),
    .mcu_run_out(mcu_run_out), .power_mode_out(power_mode_out),
    .fast_crystal_ready_irq_out(fast_crystal_ready_irq_out)
);

// *** verification/test_clock_power_mode_control.sv ***
// Purpose: Self-checking bench for the clock and power-mode controller.
// Assumes: Zero-wait APB slave; byte address is four times the index.
// Notes:   Pin, tick and comparator wakes are pulsed here; crystal and slow clock come from the model.
`timescale 1ns/1ps
module test_clock_power_mode_control;
    // ****************
    // Bench
    // ****************
    localparam [11:0] CS = 12'h28c, PD = 12'h290, LF = 12'h2b4;
    localparam [39:0] PC = {8'h07, 8'h04, 8'h03, 8'h02, 8'h01};
    localparam [39:0] FL = {8'h40, 8'h80, 8'h20, 8'h40, 8'h80};
    localparam [47:0] LC = {8'h01, 8'h07, 8'h04, 8'h03, 8'h02, 8'h00};
    reg        clk_in = 1'b0, sys_rst_in = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg        wp = 1'b0, wt = 1'b0, wc = 1'b0, lf_on = 1'b1;
    reg [11:0] paddr = 12'h0;
    reg [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire [2:0] lfsrc, pmode;
    wire       pready, pslverr, xrdy, lfclk, lfrdy, xen, rcen, mclk, msx, mrun, srst, irq, msb;
    integer    num_errors = 0, cmp_count = 0, rst_cnt = 0, irq_cnt = 0, i, p;

    cpmc_top DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .fast_crystal_ready_in(xrdy),
        .fast_rc_ready_in(rcen), .crystal_input_pin_in(1'b0), .low_freq_clock_in(lfclk),
        .low_freq_ready_in(lfrdy), .wake_pin_in(wp), .wake_tick_in(wt), .wake_comp_in(wc),
        .wake_irq_in(1'b0), .fast_crystal_osc_en_out(xen), .fast_rc_osc_en_out(rcen),
        .low_freq_src_out(lfsrc), .mcu_clk_en_out(mclk), .mcu_src_crystal_out(msx),
        .mcu_src_bypass_out(msb), .mcu_run_out(mrun), .power_mode_out(pmode),
        .system_reset_req_out(srst), .fast_crystal_ready_irq_out(irq));
    cpmc_osc_model u_osc (.clk_in(clk_in), .xtal_en_in(xen), .lf_on_in(lf_on),
        .xtal_rdy_out(xrdy), .lf_clk_out(lfclk), .lf_rdy_out(lfrdy));

    initial
        forever #10 clk_in = ~clk_in;
    always @(posedge clk_in)
    begin
        rst_cnt = rst_cnt + (srst === 1'b1);
        irq_cnt = irq_cnt + (irq === 1'b1);
    end
    task end_sim;
    begin
        $display("errors=%0d compares=%0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    task chk(input [15:0] got, input [15:0] exp);
    begin
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    task hung;
    begin
        chk(16'h0, 16'h1);
        end_sim;
    end
    endtask
    // The request stays put until pready is seen high at a rising edge.
    task apb(input [11:0] a, input w, input [7:0] d, input [7:0] e, input [7:0] m, input err);
        integer n;
    begin
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk_in);
        penable <= 1'b1;
        n = 0;
        @(posedge clk_in);
        while (pready !== 1'b1 && n < 9)
        begin
            n = n + 1;
            @(posedge clk_in);
        end
        if (n == 9)
            hung;
        chk(16'(pslverr), 16'(err));
        if (!w)
            chk(16'(prdata & {24'h0, m}), 16'(e));
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask
    task tick_gap(output integer c);
    begin
        c = 1;
        @(posedge clk_in);
        while (mclk !== 1'b1 && c < 999)
        begin
            c = c + 1;
            @(posedge clk_in);
        end
        if (c == 999)
            hung;
    end
    endtask
    task sleep(input [7:0] code, input [2:0] wk, input xon);
    begin
        apb(PD, 1'b1, code, 8'h0, 8'h0, 1'b0);
        repeat (3) @(posedge clk_in);
        chk(16'(pmode), 16'(code));
        chk(16'(xen), 16'(xon));
        {wp, wt, wc} <= wk;
        @(posedge clk_in);
        {wp, wt, wc} <= 3'h0;
    end
    endtask
    task wait_idle;
        integer n;
    begin
        n = 0;
        while (!(pmode === 3'h0 && mrun === 1'b1) && n < 200)
        begin
            n = n + 1;
            @(posedge clk_in);
        end
        if (n == 200)
            hung;
    end
    endtask
    initial
    begin
        repeat (8) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        apb(CS, 1'b0, 8'h0, 8'h00, 8'hff, 1'b0);
        apb(PD, 1'b0, 8'h0, 8'h00, 8'hff, 1'b0);
        apb(LF, 1'b0, 8'h0, 8'h47, 8'h47, 1'b0);
        chk(16'({xen, rcen, lfsrc}), 16'h1f);
        apb(12'h100, 1'b1, 8'hff, 8'h0, 8'h0, 1'b1);
        apb(12'h100, 1'b0, 8'h0, 8'h0, 8'hff, 1'b1);
        apb(CS, 1'b1, 8'h4d, 8'h0, 8'h0, 1'b0);
        apb(CS, 1'b0, 8'h0, 8'h4d, 8'hff, 1'b0);
        chk(16'(msb), 16'h1);
        for (i = 0; i < 8; i = i + 1)
        begin
            apb(CS, 1'b1, 8'h80 | i[7:0], 8'h0, 8'h0, 1'b0);
            tick_gap(p);
            tick_gap(p);
            chk(16'(p), 16'(3 << i));
        end
        for (i = 0; i < 6; i = i + 1)
        begin
            apb(LF, 1'b1, LC[8*i +: 8], 8'h0, 8'h0, 1'b0);
            apb(LF, 1'b0, 8'h0, LC[8*i +: 8], 8'h07, 1'b0);
            chk(16'(lfsrc), 16'(LC[8*i +: 8]));
        end
        apb(CS, 1'b1, 8'h88, 8'h0, 8'h0, 1'b0);
        apb(PD, 1'b1, 8'h05, 8'h0, 8'h0, 1'b0);
        apb(PD, 1'b1, 8'h06, 8'h0, 8'h0, 1'b0);
        apb(PD, 1'b0, 8'h0, 8'h00, 8'h07, 1'b0);
        p = irq_cnt;
        for (i = 0; i < 5; i = i + 1)
        begin
            sleep(PC[8*i +: 8], FL[8*i+5 +: 3], PC[8*i+2]);
            wait_idle;
            apb(PD, 1'b0, 8'h0, FL[8*i +: 8] | PC[8*i +: 8], 8'hff, 1'b0);
            apb(PD, 1'b0, 8'h0, PC[8*i +: 8], 8'hff, 1'b0);
            apb(PD, 1'b1, 8'h00, 8'h0, 8'h0, 1'b0);
            repeat (20) @(posedge clk_in);
        end
        chk(16'(rst_cnt), 16'h3);
        chk(16'(irq_cnt - p), 16'h3);
        apb(CS, 1'b1, 8'h18, 8'h0, 8'h0, 1'b0);
        chk(16'(xen), 16'h1);
        sleep(8'h01, 3'h4, 1'b0);
        wait_idle;
        chk(16'({xen, rcen}), 16'h1);
        apb(LF, 1'b0, 8'h0, 8'h00, 8'h08, 1'b0);
        apb(CS, 1'b1, 8'h08, 8'h0, 8'h0, 1'b0);
        sleep(8'h01, 3'h4, 1'b0);
        wait_idle;
        repeat (30) @(posedge clk_in);
        chk(16'(msx), 16'h1);
        apb(LF, 1'b0, 8'h0, 8'h08, 8'h08, 1'b0);
        lf_on <= 1'b0;
        apb(LF, 1'b0, 8'h0, 8'h01, 8'hc7, 1'b0);
        sleep(8'h02, 3'h4, 1'b0);
        repeat (20) @(posedge clk_in);
        chk(16'(pmode), 16'h2);
        lf_on <= 1'b1;
        wait_idle;
        end_sim;
    end
endmodule
